// File: core/dmarl_channel.sv
// One DMA channel with source address reload and indirect source addressing
// Notes on behaviour
// - With reload on, the source address returns to its start value after every fourth transfer.
// - With reload on, the channel stops after the fourth transfer of a group and drops its bus request.
// - With reload off, the channel keeps running past the fourth transfer and the source keeps stepping per its mode.
// - The destination address follows its own mode whether reload is on or off.
// - At a reload stop the peripheral request flag is cleared and no interrupt is raised unless the count also reaches zero.
// - When the count reaches zero with the end interrupt enabled, an interrupt is raised.
// - When the count reaches zero, the peripheral request flag is cleared.
// - In burst mode the channel keeps the bus and runs transfers back to back.
// - In indirect mode the longword at the source address is read first and used as the real source.
// - The indirect pointer read is always a longword access.
// - In indirect mode the source address steps by four per its mode.
// - The destination write in indirect mode is a normal write of the configured size and mode.
module dmarl_channel
  import dmarl_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Channel configuration, sampled at start
  input  wire logic                     start,
  input  wire logic [dmarl_pkg::ADDR_W-1:0] source_address_reg_init,
  input  wire logic [dmarl_pkg::ADDR_W-1:0] dest_address_reg_init,
  input  wire logic [dmarl_pkg::CNT_W-1:0]  transfer_count_reg_init,
  input  wire logic                     xfer_size_sel_lo,
  input  wire logic                     xfer_size_sel_hi,
  input  wire logic                     src_addr_mode_lo,
  input  wire logic                     src_addr_mode_hi,
  input  wire logic [1:0]               dst_addr_mode,
  input  wire logic                     reload_en,
  input  wire logic                     indirect_en,
  input  wire logic                     burst_mode,
  input  wire logic                     end_interrupt_enable,
  // Peripheral request
  input  wire logic                     periph_req,
  output logic                          periph_req_clear,
  // System bus master
  output logic                          bus_req,
  input  wire logic                     bus_grant,
  output logic                          mem_valid,
  output logic                          mem_write,
  output logic [1:0]                    mem_size,
  output logic [dmarl_pkg::ADDR_W-1:0]  mem_addr,
  output logic [dmarl_pkg::DATA_W-1:0]  mem_wdata,
  input  wire logic                     mem_ready,
  input  wire logic [dmarl_pkg::DATA_W-1:0] mem_rdata,
  // Status
  output logic                          busy,
  output logic                          end_irq,
  output logic [dmarl_pkg::ADDR_W-1:0]  source_address_reg,
  output logic [dmarl_pkg::ADDR_W-1:0]  dest_address_reg,
  output logic [dmarl_pkg::CNT_W-1:0]   transfer_count_reg
);
  import dmarl_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_REQ,
    ST_PTR_RD,
    ST_DATA_RD,
    ST_DATA_WR
  } dmarl_state_t;

  logic         rst_meta_r;
  logic         rst_sync_r;
  dmarl_state_t state_r;
  logic [ADDR_W-1:0] sar_r;
  logic [ADDR_W-1:0] sar_init_r;
  logic [ADDR_W-1:0] dar_r;
  logic [ADDR_W-1:0] real_src_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [DATA_W-1:0] data_r;
  logic [1:0]        grp_r;
  dmarl_size_t       size_r;
  dmarl_amode_t      smode_r;
  dmarl_amode_t      dmode_r;
  logic              reload_r;
  logic              indirect_r;
  logic              burst_r;
  logic              ie_r;
  logic              clr_r;
  logic              irq_r;
  logic [ADDR_W-1:0] unit_step;
  logic [ADDR_W-1:0] src_step;
  logic              wr_done;
  logic              last_cnt;
  logic              grp_end;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Step sizes for the data unit and the source pointer
  always_comb
  begin
    unique case (size_r)
      DMARL_SZ_BYTE: unit_step = STEP_BYTE;
      DMARL_SZ_WORD: unit_step = STEP_WORD;
      default:       unit_step = STEP_LONG;
    endcase
    src_step = indirect_r ? STEP_LONG : unit_step;
  end

  assign wr_done  = (state_r == ST_DATA_WR) && mem_ready;
  assign last_cnt = (cnt_r == CNT_ONE);
  assign grp_end  = reload_r && (grp_r == GROUP_LAST);

  // Channel sequencer
  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      state_r <= ST_IDLE;
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (start && (transfer_count_reg_init != CNT_ZERO))
            state_r <= ST_WAIT_REQ;
        ST_WAIT_REQ:
          if (periph_req && bus_grant)
            state_r <= indirect_r ? ST_PTR_RD : ST_DATA_RD;
        ST_PTR_RD:
          if (mem_ready)
            state_r <= ST_DATA_RD;
        ST_DATA_RD:
          if (mem_ready)
            state_r <= ST_DATA_WR;
        ST_DATA_WR:
          if (mem_ready)
          begin
            if (last_cnt || grp_end)
              state_r <= ST_IDLE;
            else if (burst_r)
              state_r <= indirect_r ? ST_PTR_RD : ST_DATA_RD;
            else
              state_r <= ST_WAIT_REQ;
          end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Configuration capture at start
  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      size_r     <= DMARL_SZ_BYTE;
      smode_r    <= DMARL_AM_FIXED;
      dmode_r    <= DMARL_AM_FIXED;
      reload_r   <= 1'b0;
      indirect_r <= 1'b0;
      burst_r    <= 1'b0;
      ie_r       <= 1'b0;
      sar_init_r <= ADDR_ZERO;
    end
    else if (state_r == ST_IDLE && start)
    begin
      size_r     <= dmarl_size_t'({xfer_size_sel_hi, xfer_size_sel_lo});
      smode_r    <= dmarl_amode_t'({src_addr_mode_hi, src_addr_mode_lo});
      dmode_r    <= dmarl_amode_t'(dst_addr_mode);
      reload_r   <= reload_en;
      indirect_r <= indirect_en;
      burst_r    <= burst_mode;
      ie_r       <= end_interrupt_enable;
      sar_init_r <= source_address_reg_init;
    end
  end

  // Source address, reload group position
  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      sar_r <= ADDR_ZERO;
      grp_r <= GROUP_FIRST;
    end
    else if (state_r == ST_IDLE && start)
    begin
      sar_r <= source_address_reg_init;
      grp_r <= GROUP_FIRST;
    end
    else if (wr_done)
    begin
      grp_r <= grp_r + 2'h1;
      if (grp_end)
        sar_r <= sar_init_r;
      else if (smode_r == DMARL_AM_INC)
        sar_r <= sar_r + src_step;
      else if (smode_r == DMARL_AM_DEC)
        sar_r <= sar_r - src_step;
    end
  end

  // Destination address, independent of reload
  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      dar_r <= ADDR_ZERO;
    else if (state_r == ST_IDLE && start)
      dar_r <= dest_address_reg_init;
    else if (wr_done && dmode_r == DMARL_AM_INC)
      dar_r <= dar_r + unit_step;
    else if (wr_done && dmode_r == DMARL_AM_DEC)
      dar_r <= dar_r - unit_step;
  end

  // Transfer count
  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      cnt_r <= CNT_ZERO;
    else if (state_r == ST_IDLE && start)
      cnt_r <= transfer_count_reg_init;
    else if (wr_done)
      cnt_r <= cnt_r - CNT_ONE;
  end

  // Pointer and data capture
  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      real_src_r <= ADDR_ZERO;
      data_r     <= DATA_ZERO;
    end
    else if (mem_ready && state_r == ST_PTR_RD)
      real_src_r <= mem_rdata;
    else if (mem_ready && state_r == ST_DATA_RD)
      data_r <= mem_rdata;
  end

  // End-of-group and end-of-count side effects
  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      clr_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      clr_r <= wr_done && (last_cnt || grp_end);
      irq_r <= wr_done && last_cnt && ie_r;
    end
  end

  // Bus drive
  always_comb
  begin
    mem_valid = 1'b0;
    mem_write = 1'b0;
    mem_size  = size_r;
    mem_addr  = sar_r;
    unique case (state_r)
      ST_PTR_RD:
      begin
        mem_valid = 1'b1;
        mem_size  = DMARL_SZ_LONG;
      end
      ST_DATA_RD:
      begin
        mem_valid = 1'b1;
        mem_addr  = indirect_r ? real_src_r : sar_r;
      end
      ST_DATA_WR:
      begin
        mem_valid = 1'b1;
        mem_write = 1'b1;
        mem_addr  = dar_r;
      end
      default:
        mem_valid = 1'b0;
    endcase
  end

  // Bus held through a burst, dropped at stop
  assign bus_req = (state_r != ST_IDLE) &&
                   ((state_r != ST_WAIT_REQ) || periph_req);
  assign mem_wdata          = data_r;
  assign busy               = (state_r != ST_IDLE);
  assign periph_req_clear   = clr_r;
  assign end_irq            = irq_r;
  assign source_address_reg = sar_r;
  assign dest_address_reg   = dar_r;
  assign transfer_count_reg = cnt_r;
endmodule

// File: core/dmarl_pkg.sv
// Package for the reload/indirect DMA channel: modes, sizes, constants
package dmarl_pkg;
  localparam int          ADDR_W         = 32;
  localparam int          DATA_W         = 32;
  localparam int          CNT_W          = 24;
  localparam logic [1:0]  GROUP_LAST     = 2'h3;     // Fourth transfer of a reload group
  localparam logic [1:0]  GROUP_FIRST    = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ONE   = 24'h00_0001;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 24'h00_0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [ADDR_W-1:0] STEP_WORD = 32'h0000_0002;
  localparam logic [ADDR_W-1:0] STEP_LONG = 32'h0000_0004;

  // Address mode select, two bits
  typedef enum logic [1:0] {
    DMARL_AM_FIXED = 2'h0,
    DMARL_AM_INC   = 2'h1,
    DMARL_AM_DEC   = 2'h2,
    DMARL_AM_RSVD  = 2'h3
  } dmarl_amode_t;

  // Transfer size select, two bits
  typedef enum logic [1:0] {
    DMARL_SZ_BYTE = 2'h0,
    DMARL_SZ_WORD = 2'h1,
    DMARL_SZ_LONG = 2'h2,
    DMARL_SZ_RSVD = 2'h3
  } dmarl_size_t;
endpackage

// File: verification/dmarl_mem.sv
// Behavioural system memory answering the channel
module dmarl_mem
  import dmarl_pkg::*;
(
  input wire logic        clk,
  input wire logic        slow,
  input wire logic        mem_valid,
  input wire logic [31:0] mem_addr,
  output logic            mem_ready,
  output logic [31:0]     mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0]  wait_r = 2'h0;
  logic [31:0] junk_r = 32'h5a5a_5a5a;
  // Ready after zero or two waits; data only with ready
  assign mem_ready = mem_valid && (wait_r == (slow ? 2'h2 : 2'h0));
  assign mem_rdata = mem_ready ? mem_addr ^ 32'h0001_0000 : junk_r;
  // Wait counter and changing junk
  always @(posedge clk)
  begin
    wait_r <= (mem_valid && !mem_ready) ? wait_r + 2'h1 : 2'h0;
    junk_r <= {junk_r[30:0], ~junk_r[31]};
  end
endmodule

// File: verification/dmarl_properties.sv
// Port checker for the reload/indirect DMA channel
module dmarl_props
  import dmarl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        busy,
  input wire logic        bus_req,
  input wire logic        periph_req_clear,
  input wire logic        end_irq,
  input wire logic        mem_valid,
  input wire logic        mem_write,
  input wire logic        mem_ready,
  input wire logic [1:0]  mem_size,
  input wire logic [31:0] mem_addr,
  input wire logic        xfer_size_sel_hi,
  input wire logic        xfer_size_sel_lo,
  input wire logic [1:0]  dst_addr_mode,
  input wire logic [31:0] dest_address_reg,
  input wire logic [23:0] transfer_count_reg
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Unit step and write completion
  wire [31:0] st = xfer_size_sel_hi ? STEP_LONG : xfer_size_sel_lo ? STEP_WORD : STEP_BYTE;
  wire        wd = mem_valid && mem_write && mem_ready;
  wire [1:0]  sz = {xfer_size_sel_hi, xfer_size_sel_lo};
  a_stop_release: assert property ($fell(busy) |-> !bus_req && periph_req_clear)
    else $error("stop without bus release or flag clear");
  a_irq_at_zero: assert property (end_irq |-> transfer_count_reg == CNT_ZERO)
    else $error("end interrupt with nonzero count");
  a_irq_clears_flag: assert property (end_irq |-> periph_req_clear)
    else $error("end interrupt without flag clear");
  a_count_step: assert property (wd |=> transfer_count_reg == $past(transfer_count_reg) - CNT_ONE)
    else $error("count not decremented by one");
  a_access_held: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr))
    else $error("access dropped before ready");
  a_write_size: assert property (mem_valid && mem_write |-> mem_size == sz)
    else $error("write size differs from setting");
  a_dest_inc: assert property
    (wd && dst_addr_mode == 2'h1 |=> dest_address_reg == $past(dest_address_reg) + $past(st))
    else $error("destination not incremented");
  a_dest_dec: assert property
    (wd && dst_addr_mode == 2'h2 |=> dest_address_reg == $past(dest_address_reg) - $past(st))
    else $error("destination not decremented");
  cover property (end_irq);
  cover property ($fell(busy) && !end_irq);
  cover property (mem_valid && !mem_ready);
endmodule

// File: verification/test_dmarl_channel.sv
// Self-checking bench for the reload/indirect DMA channel
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", n, e, s); end end
module test_dmarl_channel
  import dmarl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_n = 0, start = 0, periph_req = 1, bus_grant = 1, slow = 0;
  logic xfer_size_sel_lo = 0, xfer_size_sel_hi = 0, src_addr_mode_lo = 0, src_addr_mode_hi = 0;
  logic reload_en = 0, indirect_en = 0, burst_mode = 0, end_interrupt_enable = 0;
  logic [1:0] dst_addr_mode = 0, mem_size;
  logic [31:0] source_address_reg_init = 0, dest_address_reg_init = 0, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] source_address_reg, dest_address_reg, es, ed;
  logic [23:0] transfer_count_reg_init = 0, transfer_count_reg;
  logic periph_req_clear, bus_req, mem_valid, mem_write, mem_ready, busy, end_irq, ph;
  int mismatches = 0, comparisons = 0, cyc = 0, n, irqs, clrs, held;
  wire [31:0] st = xfer_size_sel_hi ? STEP_LONG : xfer_size_sel_lo ? STEP_WORD : STEP_BYTE;
  dmarl_channel dmarl_channel_i (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .start                   (start),
    .source_address_reg_init (source_address_reg_init),
    .dest_address_reg_init   (dest_address_reg_init),
    .transfer_count_reg_init (transfer_count_reg_init),
    .xfer_size_sel_lo        (xfer_size_sel_lo),
    .xfer_size_sel_hi        (xfer_size_sel_hi),
    .src_addr_mode_lo        (src_addr_mode_lo),
    .src_addr_mode_hi        (src_addr_mode_hi),
    .dst_addr_mode           (dst_addr_mode),
    .reload_en               (reload_en),
    .indirect_en             (indirect_en),
    .burst_mode              (burst_mode),
    .end_interrupt_enable    (end_interrupt_enable),
    .periph_req              (periph_req),
    .periph_req_clear        (periph_req_clear),
    .bus_req                 (bus_req),
    .bus_grant               (bus_grant),
    .mem_valid               (mem_valid),
    .mem_write               (mem_write),
    .mem_size                (mem_size),
    .mem_addr                (mem_addr),
    .mem_wdata               (mem_wdata),
    .mem_ready               (mem_ready),
    .mem_rdata               (mem_rdata),
    .busy                    (busy),
    .end_irq                 (end_irq),
    .source_address_reg      (source_address_reg),
    .dest_address_reg        (dest_address_reg),
    .transfer_count_reg      (transfer_count_reg)
  );
  dmarl_mem dmarl_mem_i (
    .clk                     (clk),
    .slow                    (slow),
    .mem_valid               (mem_valid),
    .mem_addr                (mem_addr),
    .mem_ready               (mem_ready),
    .mem_rdata               (mem_rdata)
  );
  initial forever #2.5 clk = ~clk;
  function automatic logic [31:0] nx(logic [31:0] a, logic [1:0] m, logic [31:0] s);
    return m == 2'h1 ? a + s : m == 2'h2 ? a - s : a;
  endfunction
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watch settled accesses ahead of the completing edge
  always @(negedge clk)
  begin
    if (++cyc > 5000)
    begin
      mismatches++;
      complete_run();
    end
    irqs += end_irq;
    clrs += periph_req_clear;
    held += busy && !bus_req;
    if (mem_valid && mem_ready && !mem_write)
    begin
      if (indirect_en && !ph) `CHK("ptr", {2'h2, es}, {mem_size, mem_addr})
      else `CHK("rd", indirect_en ? es ^ 32'h0001_0000 : es, mem_addr)
      ph = indirect_en && !ph;
    end
    if (mem_valid && mem_ready && mem_write)
    begin
      `CHK("wr", {ed, indirect_en ? es : es ^ 32'h0001_0000}, {mem_addr, mem_wdata})
      ed = nx(ed, dst_addr_mode, st);
      es = (reload_en && n == 3) ? source_address_reg_init
         : nx(es, {src_addr_mode_hi, src_addr_mode_lo}, indirect_en ? STEP_LONG : st);
      n = (n + 1) % 4;
    end
  end
  // One channel run; cf = {size, src mode, dst mode, reload, indirect, burst, irq enable}
  task automatic run(logic [31:0] s, d, logic [23:0] c, logic [9:0] cf);
    logic [23:0] left;
    @(negedge clk);
    {xfer_size_sel_hi, xfer_size_sel_lo, src_addr_mode_hi, src_addr_mode_lo, dst_addr_mode,
     reload_en, indirect_en, burst_mode, end_interrupt_enable} = cf;
    {source_address_reg_init, dest_address_reg_init, transfer_count_reg_init, es, ed} = {s, d, c, s, d};
    {n, ph, irqs, clrs, held} = 0;
    start = 1;
    @(negedge clk) start = 0;
    repeat (300)
    begin
      @(negedge clk);
      // Burst: request low during each access, bus must stay held; cycle steal: one idle gap per write
      periph_req <= !(mem_valid && (burst_mode || (mem_write && mem_ready)));
      if (!busy) break;
    end
    // End pulses counted by the monitor first
    @(negedge clk);
    left = (reload_en && c > 24'h4) ? c - 24'h4 : 24'h0;
    `CHK("cnt", left, transfer_count_reg)
    `CHK("src", es, source_address_reg)
    `CHK("dst", ed, dest_address_reg)
    `CHK("irq", 32'(end_interrupt_enable && left == 0), irqs)
    `CHK("clr", 1, clrs)
    `CHK("held", burst_mode ? 0 : int'(c) - 1, held)
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    // Reload in burst mode with counts in fours
    run(32'h0400_0080, 32'h0040_0000, 24'h00_0008, 10'h26B);
    run(32'h0400_0080, 32'h0040_0000, 24'h00_0004, 10'h26B);
    slow = 1;
    run(32'h0000_1000, 32'h0000_2000, 24'h00_0006, 10'h193);
    run(32'h0040_0000, 32'h0400_0156, 24'h00_0003, 10'h044);
    complete_run();
  end
endmodule
bind dmarl_channel dmarl_props dmarl_props_i (
  .clk                (clk),
  .rst_n              (rst_n),
  .busy               (busy),
  .bus_req            (bus_req),
  .periph_req_clear   (periph_req_clear),
  .end_irq            (end_irq),
  .mem_valid          (mem_valid),
  .mem_write          (mem_write),
  .mem_ready          (mem_ready),
  .mem_size           (mem_size),
  .mem_addr           (mem_addr),
  .xfer_size_sel_hi   (xfer_size_sel_hi),
  .xfer_size_sel_lo   (xfer_size_sel_lo),
  .dst_addr_mode      (dst_addr_mode),
  .dest_address_reg   (dest_address_reg),
  .transfer_count_reg (transfer_count_reg)
);
